// ===== irc_device.sv
// Sensor end: two-wire slave with command decoder on the link clock
`timescale 1ns/10ps
module irc_device (
  input wire logic LINK_CLK,
  input wire logic RSTN,
  irc_link_if.dev LINK,
  output logic BEGIN_SINGLE_CAPTURE,
  input wire logic CAPTURE_DONE,
  output logic CAPTURE_BUSY,
  output logic [7:0] RD_ADDR,
  input wire logic [15:0] RD_DATA,
  output logic [15:0] CFG_VALUE,
  output logic [15:0] TRIM_VALUE,
  output logic [4:0] RESULT_BITS
);
  import irc_pkg::*;

  typedef struct packed {
    logic scl_p;
    logic sda_p;
    phase_e ph;
    logic [3:0] bc;
    logic [7:0] sr;
    logic oe;
    logic nack;
    logic [2:0] bidx;
    logic [7:0] op;
    logic [7:0] chk;
    logic [7:0] dlo;
    logic ok;
    logic arm;
    logic [7:0] addr;
    logic [7:0] step;
    logic [7:0] cnt;
    logic hi;
    logic [15:0] txw;
    logic [15:0] cfg;
    logic [15:0] trim;
    logic [4:0] res;
    logic busy;
    logic done;
    logic cap;
  } dev_s;

  dev_s q, d;
  logic [1:0] pins;
  logic scl_s, sda_s, scl_r, scl_f, start, stop;
  logic [15:0] word;
  logic [7:0] tx_byte;

  irc_sync2 #(.W(2)) u_sync (
    .clk(LINK_CLK),
    .rstn(RSTN),
    .d({LINK.scl, LINK.sda}),
    .q(pins)
  );

  assign scl_s = pins[1];
  assign sda_s = pins[0];

  always_comb
  begin
    d = q;
    d.cap = 1'h0;
    word = 16'h0000;
    tx_byte = 8'hFF;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    scl_r = scl_s & ~q.scl_p;
    scl_f = ~scl_s & q.scl_p;
    start = scl_s & q.scl_p & q.sda_p & ~sda_s;
    stop = scl_s & q.scl_p & ~q.sda_p & sda_s;
    if (start)
    begin
      d.ph = PH_ADDR;
      d.bc = ACK_BIT; // The SCL fall after START ends like an ack slot
      d.oe = 1'h0;
    end
    else if (stop)
    begin
      d.ph = PH_IDLE;
      d.oe = 1'h0;
      d.arm = 1'h0;
      if (q.arm && !q.busy)
      begin
        d.cap = 1'h1;
        d.busy = 1'h1;
        d.done = 1'h0;
      end
    end
    else if (q.ph != PH_IDLE && scl_r)
    begin
      if (q.bc < ACK_BIT && q.ph != PH_TX)
        d.sr = {q.sr[6:0], sda_s};
      if (q.bc == ACK_BIT && q.ph == PH_TX)
        d.nack = sda_s;
    end
    else if (q.ph != PH_IDLE && scl_f)
    begin
      if (q.bc < 4'h7)
      begin
        d.bc = q.bc + 4'h1;
        if (q.ph == PH_TX)
        begin
          d.sr = {q.sr[6:0], 1'h0};
          d.oe = ~q.sr[6];
        end
      end
      else if (q.bc == 4'h7)
      begin
        d.bc = ACK_BIT;
        d.oe = (q.ph != PH_TX);
        unique case (q.ph)
          PH_ADDR:
          begin
            if (q.sr[7:1] != SLAVE_ADDR)
            begin
              d.ph = PH_IDLE;
              d.oe = 1'h0;
            end
            else if (q.sr[0])
            begin
              d.ph = PH_TX;
              d.nack = 1'h0;
              d.hi = 1'h0;
            end
            else
            begin
              d.ph = PH_CMD;
              d.bidx = 3'h0;
            end
          end
          PH_CMD:
          begin
            if (q.bidx != 3'h7)
              d.bidx = q.bidx + 3'h1;
            unique case (q.bidx)
              3'h0: d.op = q.sr;
              3'h1:
              begin
                if (q.op == OP_START && q.sr == START_HI)
                  d.arm = 1'h1;
                if (q.op == OP_READ)
                  d.addr = q.sr;
                d.chk = q.sr;
              end
              3'h2:
              begin
                if (q.op == OP_READ)
                  d.step = q.sr;
                d.ok = check_ok(q.chk, q.sr, op_key(q.op));
                d.dlo = q.sr;
              end
              3'h3:
              begin
                if (q.op == OP_READ)
                  d.cnt = q.sr;
                d.chk = q.sr;
              end
              3'h4:
              begin
                // Both halves must pass; otherwise keep old value
                if (q.ok && check_ok(q.chk, q.sr, op_key(q.op)))
                begin
                  if (q.op == OP_CFG)
                    d.cfg = {q.sr, q.dlo};
                  if (q.op == OP_TRIM)
                    d.trim = {q.sr, q.dlo};
                end
              end
              default: ;
            endcase
          end
          default: ;
        endcase
      end
      else
      begin
        d.bc = 4'h0;
        d.oe = 1'h0;
        if (q.ph == PH_TX && q.nack)
          d.ph = PH_IDLE;
        else if (q.ph == PH_TX)
        begin
          if (q.addr == CFG_ADDR)
          begin
            word = q.cfg;
            word[DONE_BIT] = q.done;
          end
          else if (q.addr == TRIM_ADDR)
            word = q.trim;
          else
            word = RD_DATA;
          if (!q.hi)
          begin
            d.txw = word;
            tx_byte = (q.cnt != 8'h00) ? word[7:0] : 8'hFF;
          end
          else if (q.cnt != 8'h00)
          begin
            tx_byte = q.txw[15:8];
            d.addr = q.addr + q.step;
            d.cnt = q.cnt - 8'h01;
          end
          d.hi = ~q.hi;
          d.sr = tx_byte;
          d.oe = ~tx_byte[7];
        end
      end
    end
    d.res = RES_BASE + {3'h0, d.cfg[RES_LSB +: 2]};
    if (CAPTURE_DONE)
    begin
      d.busy = 1'h0;
      d.done = 1'h1;
    end
  end

  always_ff @(posedge LINK_CLK)
  begin
    if (!RSTN)
    begin
      q <= '0;
      q.scl_p <= 1'h1;
      q.sda_p <= 1'h1;
      q.ph <= PH_IDLE;
      q.cfg <= CFG_RESET;
      q.trim <= TRIM_RESET;
      q.res <= RES_BASE;
    end
    else
      q <= d;
  end

  assign LINK.dev_sda_o = 1'h0;
  assign LINK.dev_sda_oe = q.oe;
  assign BEGIN_SINGLE_CAPTURE = q.cap;
  assign CAPTURE_BUSY = q.busy;
  assign RD_ADDR = q.addr;
  assign CFG_VALUE = q.cfg;
  assign TRIM_VALUE = q.trim;
  assign RESULT_BITS = q.res;
endmodule // irc_device

// ===== irc_pkg.sv
// Shared constants, types and helpers of the array command decoder
package irc_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h60;
  localparam logic [7:0] OP_START = 8'h01;
  localparam logic [7:0] START_HI = 8'h08;
  localparam logic [7:0] OP_READ = 8'h02;
  localparam logic [7:0] OP_CFG = 8'h03;
  localparam logic [7:0] OP_TRIM = 8'h04;
  localparam logic [7:0] CFG_KEY = 8'h55;
  localparam logic [7:0] TRIM_KEY = 8'hAA;
  localparam logic [7:0] CFG_ADDR = 8'h92;
  localparam logic [7:0] TRIM_ADDR = 8'h93;
  localparam int DONE_BIT = 9;
  localparam int RES_LSB = 4;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [4:0] RES_BASE = 5'h0F;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int CORE_MHZ = 25;
  localparam int QTR_NS = 1000;
  localparam int QTR_CYC = (QTR_NS * CORE_MHZ + 999) / 1000;
  localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_CMD = 2'b10,
    PH_TX = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } hstate_e;

  function automatic logic [7:0] op_key(input logic [7:0] op);
    return (op == OP_CFG) ? CFG_KEY : TRIM_KEY;
  endfunction

  function automatic logic check_ok(input logic [7:0] chk,
                                    input logic [7:0] data,
                                    input logic [7:0] key);
    logic [7:0] sum;
    sum = chk + key;
    return sum == data;
  endfunction
endpackage

// ===== irc_link_if.sv
// Two-wire link between master and sensor command decoder
`timescale 1ns/10ps
interface irc_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open-drain wire with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe,
                input sda);
  modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

// ===== irc_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module irc_sync2 #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s r_q, r_d;

  always_comb
  begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  // Idle bus level is high
  always_ff @(posedge clk)
  begin
    if (!rstn)
      r_q <= '1;
    else
      r_q <= r_d;
  end

  assign q = r_q.s2;
endmodule // irc_sync2

// ===== irc_host.sv
// Master end: sequences commands onto the two-wire link
`timescale 1ns/10ps
module irc_host (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  irc_link_if.host LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_OP,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [7:0] CMD_STEP,
  input wire logic [7:0] CMD_COUNT,
  input wire logic [15:0] CMD_WDATA,
  output logic RD_VALID,
  output logic [15:0] RD_WORD,
  output logic DONE,
  output logic NACK_ERR
);
  import irc_pkg::*;

  typedef struct packed {
    hstate_e st;
    logic [1:0] qc;
    logic [4:0] tk;
    logic [3:0] bc;
    logic [7:0] sr;
    logic oe;
    logic scl;
    logic [2:0] k;
    logic rd;
    logic rx;
    logic [8:0] rem;
    logic [7:0] op;
    logic [7:0] a;
    logic [7:0] s;
    logic [7:0] c;
    logic [15:0] w;
    logic [7:0] lo;
    logic rv;
    logic [15:0] rw;
    logic done;
    logic err;
  } host_s;

  host_s q, d;
  logic sda_s, tick;
  logic [2:0] last;

  irc_sync2 #(.W(1)) u_sync (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .d(LINK.sda),
    .q(sda_s)
  );

  function automatic logic [7:0] wr_byte(input logic [2:0] k,
                                         input host_s h);
    logic [7:0] b;
    b = {SLAVE_ADDR, 1'h0};
    unique case (k)
      3'h1: b = h.op;
      3'h2: b = (h.op == OP_START) ? START_HI :
                (h.op == OP_READ) ? h.a : h.w[7:0] - op_key(h.op);
      3'h3: b = (h.op == OP_READ) ? h.s : h.w[7:0];
      3'h4: b = (h.op == OP_READ) ? h.c : h.w[15:8] - op_key(h.op);
      3'h5: b = h.w[15:8];
      default: ;
    endcase
    return b;
  endfunction

  always_comb
  begin
    d = q;
    d.rv = 1'h0;
    d.done = 1'h0;
    tick = (q.tk == QTR_LAST);
    d.tk = tick ? 5'h00 : q.tk + 5'h01;
    unique case (q.op)
      OP_START: last = 3'h2;
      OP_READ: last = 3'h4;
      OP_CFG, OP_TRIM: last = 3'h5;
      default: last = 3'h1;
    endcase
    unique case (q.st)
      H_IDLE:
      begin
        d.tk = 5'h00;
        if (CMD_VALID)
        begin
          d.st = H_START;
          d.op = CMD_OP;
          d.a = CMD_ADDR;
          d.s = CMD_STEP;
          d.c = CMD_COUNT;
          d.w = CMD_WDATA;
          d.scl = 1'h0;
          d.oe = 1'h0;
          d.qc = 2'h0;
          d.k = 3'h0;
          d.rd = 1'h0;
          d.rx = 1'h0;
          d.err = 1'h0;
        end
      end
      H_START, H_STOP:
      begin
        if (tick)
        begin
          d.qc = q.qc + 2'h1;
          unique case (q.qc)
            2'h0: d.oe = (q.st == H_STOP);
            2'h1: d.scl = 1'h1;
            2'h2: d.oe = (q.st == H_START);
            2'h3:
            begin
              if (q.st == H_START)
              begin
                d.st = H_BIT;
                d.scl = 1'h0;
                d.bc = 4'h0;
                d.sr = q.rd ? {SLAVE_ADDR, 1'h1} : wr_byte(3'h0, q);
              end
              else
              begin
                d.st = H_IDLE;
                d.scl = 1'h1;
                d.done = 1'h1;
              end
            end
          endcase
        end
      end
      H_BIT:
      begin
        if (tick)
        begin
          d.qc = q.qc + 2'h1;
          unique case (q.qc)
            2'h0:
            begin
              // Data changes a quarter after the falling clock edge
              if (q.bc == ACK_BIT)
                d.oe = q.rx & (q.rem != 9'h001);
              else
                d.oe = ~q.rx & ~q.sr[7];
            end
            2'h1: d.scl = 1'h1;
            2'h2: ;
            2'h3:
            begin
              d.scl = 1'h0;
              if (q.bc != ACK_BIT)
              begin
                d.sr = {q.sr[6:0], q.rx & sda_s};
                d.bc = q.bc + 4'h1;
              end
              else
              begin
                d.bc = 4'h0;
                if (!q.rx && sda_s)
                begin
                  d.err = 1'h1;
                  d.st = H_STOP;
                end
                else if (q.rx)
                begin
                  d.rem = q.rem - 9'h001;
                  if (!q.rem[0])
                    d.lo = q.sr;
                  else
                  begin
                    d.rw = {q.sr, q.lo};
                    d.rv = 1'h1;
                  end
                  if (q.rem == 9'h001)
                    d.st = H_STOP;
                end
                else if (q.rd)
                begin
                  d.rx = 1'h1;
                  d.rem = {q.c, 1'h0};
                end
                else if (q.k == last)
                begin
                  if (q.op == OP_READ && q.c != 8'h00)
                  begin
                    d.rd = 1'h1;
                    d.st = H_START;
                  end
                  else
                    d.st = H_STOP;
                end
                else
                begin
                  d.k = q.k + 3'h1;
                  d.sr = wr_byte(q.k + 3'h1, q);
                end
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      q <= '0;
      q.st <= H_IDLE;
      q.scl <= 1'h1;
    end
    else
      q <= d;
  end

  assign CMD_READY = (q.st == H_IDLE);
  assign LINK.scl = q.scl;
  assign LINK.host_sda_o = 1'h0;
  assign LINK.host_sda_oe = q.oe;
  assign RD_VALID = q.rv;
  assign RD_WORD = q.rw;
  assign DONE = q.done;
  assign NACK_ERR = q.err;
endmodule // irc_host

// ===== irc_link_props.sv
// Wire checks on the two-wire link between master and sensor ends
`timescale 1ns/10ps
module irc_link_props (
  input wire logic CORE_CLK,
  input wire logic LINK_CLK,
  input wire logic RSTN,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  import irc_pkg::*;
  localparam int HI_MIN = 2 * QTR_CYC - 3;
  localparam int HI_MAX = 2 * QTR_CYC + 3;
  logic [7:0] hi_q;
  logic sda_q, frame_q;

  // Counts clock cycles of one SCL high phase, saturating in idle
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN || !scl)
      hi_q <= 8'h00;
    else if (hi_q != 8'hFF)
      hi_q <= hi_q + 8'h01;
  end

  // Open from START to STOP; idle SCL high is no bit phase
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      sda_q <= 1'h1;
      frame_q <= 1'h0;
    end
    else
    begin
      sda_q <= sda;
      if (scl && sda_q && !sda)
        frame_q <= 1'h1;
      else if (scl && !sda_q && sda)
        frame_q <= 1'h0;
    end
  end

  a_sda_wired_and: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    sda == !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o)))
    else $error("SDA does not follow the open-drain pulls");
  a_host_pull_only: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    host_sda_oe |-> !host_sda_o)
    else $error("Master drives SDA high");
  a_dev_pull_only: assert property (
    @(posedge LINK_CLK) disable iff (!RSTN)
    dev_sda_oe |-> !dev_sda_o)
    else $error("Sensor drives SDA high");
  a_scl_high_time: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    $fell(scl) && frame_q |-> hi_q >= HI_MIN && hi_q <= HI_MAX)
    else $error("SCL high phase has wrong length");
  a_scl_low_hold: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    $fell(scl) |=> !scl [*8])
    else $error("SCL low phase too short");
  a_dev_change_low: assert property (
    @(posedge LINK_CLK) disable iff (!RSTN)
    $changed(dev_sda_oe) |-> !scl)
    else $error("Sensor moves SDA while SCL is high");
  a_stop_released: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    $rose(sda) && scl && $past(scl) |-> !$past(dev_sda_oe))
    else $error("SDA rise with SCL high came from sensor");
  a_start_by_host: assert property (
    @(posedge CORE_CLK) disable iff (!RSTN)
    $fell(sda) && scl && $past(scl) |-> host_sda_oe && !dev_sda_oe)
    else $error("SDA fall with SCL high not made by master");
endmodule // irc_link_props

// ===== ir_array_i2c_command_decoder_bench.sv
// Bench joining master and sensor ends, plus a rogue master on a spare link
`timescale 1ns/10ps
module ir_array_i2c_command_decoder_bench;
  import irc_pkg::*;
  typedef struct {logic [7:0] op, a, s, c; logic [15:0] w;} row_s;
  logic CORE_CLK = 0, LINK_CLK = 0, RSTN = 0, cmd_valid = 0, cap_done = 0;
  logic [7:0] cmd_op = 0, cmd_addr = 0, cmd_step = 0, cmd_count = 0;
  logic [15:0] cmd_wdata = 0, rd_word, cfg_v, trim_v, bad_cfg, bad_trim;
  logic cmd_ready, rd_valid, done, nack_err, cap, busy, e_done = 0;
  logic [7:0] rd_addr;
  logic [4:0] res_bits;
  logic [15:0] got[$], e_cfg = 0, e_trim = 0;
  int miscompares = 0, comparisons = 0, cycles = 0, caps = 0, acks = 0;
  row_s rows[9] = '{'{OP_CFG, 0, 0, 0, 16'h1234},
    '{OP_TRIM, 0, 0, 0, 16'hA5F0},
    '{OP_READ, 8'hFE, 8'h04, 3, 0}, '{OP_READ, 8'h10, 8'h00, 1, 0},
    '{OP_READ, 8'h20, 8'h01, 0, 0}, '{OP_CFG, 0, 0, 0, 16'h0210},
    '{OP_READ, CFG_ADDR, 8'h00, 1, 0}, '{OP_CFG, 0, 0, 0, 16'h0020},
    '{8'h07, 0, 0, 0, 0}};
  row_s rc = '{OP_READ, CFG_ADDR, 8'h00, 1, 0};
  row_s rs = '{OP_START, 0, 0, 0, 0};

  always #20 CORE_CLK = ~CORE_CLK;
  always
  begin
    #13;
    forever #80 LINK_CLK = ~LINK_CLK;
  end

  irc_link_if link();
  irc_link_if bad();
  irc_host i_irc_host (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .LINK(link.host),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_STEP(cmd_step), .CMD_COUNT(cmd_count),
    .CMD_WDATA(cmd_wdata), .RD_VALID(rd_valid), .RD_WORD(rd_word),
    .DONE(done), .NACK_ERR(nack_err));
  irc_device i_irc_device (.LINK_CLK(LINK_CLK), .RSTN(RSTN), .LINK(link.dev),
    .BEGIN_SINGLE_CAPTURE(cap), .CAPTURE_DONE(cap_done), .CAPTURE_BUSY(busy),
    .RD_ADDR(rd_addr), .RD_DATA({~rd_addr, rd_addr}), .CFG_VALUE(cfg_v),
    .TRIM_VALUE(trim_v), .RESULT_BITS(res_bits));
  irc_device i_irc_device_bad (.LINK_CLK(LINK_CLK), .RSTN(RSTN),
    .LINK(bad.dev), .BEGIN_SINGLE_CAPTURE(), .CAPTURE_DONE(1'b0),
    .CAPTURE_BUSY(), .RD_ADDR(), .RD_DATA(16'h0000), .CFG_VALUE(bad_cfg),
    .TRIM_VALUE(bad_trim), .RESULT_BITS());
  irc_link_props i_irc_link_props (.CORE_CLK(CORE_CLK), .LINK_CLK(LINK_CLK),
    .RSTN(RSTN), .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [15:0] ew(input logic [7:0] a);
    if (a == CFG_ADDR)
      return {e_cfg[15:10], e_done, e_cfg[8:0]};
    return (a == TRIM_ADDR) ? e_trim : {~a, a};
  endfunction

  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (rd_valid === 1'b1)
      got.push_back(rd_word);
    if (cycles == 95000)
    begin
      miscompares++;
      stop_test();
    end
  end

  always @(posedge LINK_CLK)
    if (cap === 1'b1)
    begin
      caps++;
      cmp("cap_at_stop", 16'h0001, {15'h0000, link.scl & link.sda});
    end

  // One host command, then its nack, cfg, trim, result bits and read words against expectations
  task automatic run(input row_s r);
    int n;
    logic [7:0] ad;
    got.delete();
    @(posedge CORE_CLK);
    cmd_op <= r.op;
    cmd_addr <= r.a;
    cmd_step <= r.s;
    cmd_count <= r.c;
    cmd_wdata <= r.w;
    cmd_valid <= 1'b1;
    @(posedge CORE_CLK);
    while (cmd_ready !== 1'b1)
      @(posedge CORE_CLK);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 30000)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    cmp("done", 16'h0001, {15'h0000, done});
    repeat (4) @(posedge CORE_CLK);
    if (r.op == OP_CFG)
      e_cfg = r.w;
    if (r.op == OP_TRIM)
      e_trim = r.w;
    cmp("nack", 16'h0000, {15'h0000, nack_err});
    cmp("cfg", e_cfg, cfg_v);
    cmp("trim", e_trim, trim_v);
    cmp("bits", {11'h000, RES_BASE + e_cfg[5:4]}, 16'(res_bits));
    cmp("words", {8'h00, r.c}, 16'(got.size()));
    ad = r.a;
    foreach (got[i])
    begin
      cmp("word", ew(ad), got[i]);
      ad = ad + r.s;
    end
    $display("test op %h addr %h done", r.op, r.a);
  endtask

  task automatic qt();
    repeat (QTR_CYC) @(posedge CORE_CLK);
  endtask

  // Master frame on the spare link; check bytes are given raw
  task automatic frame(input logic [7:0] b[6]);
    logic [8:0] sh;
    bad.host_sda_oe <= 1'b1;
    qt();
    bad.scl <= 1'b0;
    qt();
    for (int i = 0; i < 6; i++)
    begin
      sh = {b[i], 1'b1};
      for (int k = 0; k < 9; k++)
      begin
        bad.host_sda_oe <= !sh[8];
        sh = sh << 1;
        qt();
        bad.scl <= 1'b1;
        qt();
        qt();
        if (k == 8 && bad.sda === 1'b0)
          acks++;
        bad.scl <= 1'b0;
        qt();
      end
    end
    bad.host_sda_oe <= 1'b1;
    qt();
    bad.scl <= 1'b1;
    qt();
    bad.host_sda_oe <= 1'b0;
    repeat (4) qt();
  endtask

  initial
  begin
    bad.scl = 1'b1;
    bad.host_sda_oe = 1'b0;
    bad.host_sda_o = 1'b0;
    repeat (16) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    cmp("rst_cfg", 16'h0000, cfg_v);
    cmp("rst_bits", 16'h000F, {11'h000, res_bits});
    cmp("rst_idle", 16'h0003, {14'h0000, cmd_ready, link.scl});
    $display("test reset done");
    foreach (rows[i])
      run(rows[i]);
    run(rs);
    cmp("caps", 16'h0001, 16'(caps));
    cmp("busy", 16'h0001, {15'h0000, busy});
    run(rs);
    rows[0].w = 16'h0030;
    run(rows[0]);
    run(rc);
    cmp("caps", 16'h0001, 16'(caps));
    @(posedge LINK_CLK);
    cap_done <= 1'b1;
    @(posedge LINK_CLK);
    cap_done <= 1'b0;
    repeat (4) @(posedge LINK_CLK);
    cmp("busy", 16'h0000, {15'h0000, busy});
    e_done = 1'b1;
    run(rc);
    frame('{8'hC0, OP_CFG, 8'hDF, 8'h34, 8'h00, 8'h12});
    cmp("bad_cfg", CFG_RESET, bad_cfg);
    frame('{8'hC0, OP_TRIM, 8'h8A, 8'h34, 8'h68, 8'h12});
    cmp("bad_trim", 16'h1234, bad_trim);
    cmp("acks", 16'h000C, 16'(acks));
    $display("test check bytes done");
    RSTN <= 1'b0;
    repeat (16) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    cmp("rerst", 16'h0000, cfg_v | trim_v);
    $display("test second reset done");
    stop_test();
  end
endmodule // ir_array_i2c_command_decoder_bench
